// File: common/sdc_pkg.sv
// Shared constants, command codes and types for the command and bank control link
package sdc_pkg;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int AP_BIT = 10;
    localparam int READ_LAT = 2;
    localparam int BURST_LEN = 1;
    localparam int CLK_PERIOD_NS = 25;
    localparam int PRECHARGE_PERIOD_NS = 20;
    localparam int ROW_CYCLE_PERIOD_NS = 70;
    localparam int REFRESH_COUNT = 4096;
    localparam int REFRESH_WINDOW_MS = 64;
    localparam int PRECHARGE_CYC =
        (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_CYCLE_CYC =
        (ROW_CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest gap between refreshes, rounded down
    localparam int REFRESH_GAP_CYC =
        (REFRESH_WINDOW_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_COUNT;
    localparam int RC_CNT_W = 16;
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MRS = 3'h0;
    typedef enum logic [1:0] {SDC_RUN, SDC_PDOWN, SDC_SUSPEND, SDC_SELFREF} sdc_power_e;
endpackage : sdc_pkg

// File: common/sdc_if.sv
// Pin-level link between memory controller and memory device
`timescale 1ns/1ps
interface sdc_if;
    logic clkGate;
    logic chipSelN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeStrobeN;
    logic [sdc_pkg::BANK_W-1:0] bankSelect;
    logic [sdc_pkg::ADDR_W-1:0] addr;
    logic lowerByteMask;
    logic upperByteMask;
    logic [sdc_pkg::DATA_W-1:0] dqFromCtrl;
    logic [1:0] dqOeCtrl;
    logic [sdc_pkg::DATA_W-1:0] dqFromMem;
    logic [1:0] dqOeMem;
    modport device (input clkGate, chipSelN, rowStrobeN, colStrobeN, writeStrobeN,
        bankSelect, addr, lowerByteMask, upperByteMask, dqFromCtrl, dqOeCtrl,
        output dqFromMem, dqOeMem);
    modport ctrl (output clkGate, chipSelN, rowStrobeN, colStrobeN, writeStrobeN,
        bankSelect, addr, lowerByteMask, upperByteMask, dqFromCtrl, dqOeCtrl,
        input dqFromMem, dqOeMem);
endinterface : sdc_if

// File: design/sdc_device.sv
// Memory device end: command decode, bank state, masked storage, refresh counter
// Operation
// - Activate takes whole address as row
// - Column from low bits, bit ten auto-precharge
// - Precharge bit ten high means all banks
// - Mode load takes address as opcode
// - Bank select picks target bank
// - Edge ignored while clock gate low
// - Gate low: power-down, suspend or self refresh
// - Inputs captured on rising clock edge
// - Chip select high: no command, hold state
// - Strobes decoded together form the command
// - Byte masks govern lower and upper bytes
// - Read mask acts two clocks later
// - Write mask sampled with data
// - Read from open row, optional auto close
// - Write to open row, optional auto close
// - Controller waits precharge period after precharge
// - Precharged bank idle, activate before access
// - Auto precharge per command only
// - Refresh uses internal counter, ignores address
// - Controller waits row cycle after refresh
// - Controller refreshes 4096 times per 64 ms
// - Strobe encodings as command table
// - Refresh with gate low enters self refresh
`timescale 1ns/1ps
module sdc_device #(
    parameter int DEPTH_W = 6
) (
    input wire logic clk,
    input wire logic rst,
    sdc_if.device link,
    output logic [sdc_pkg::ADDR_W-1:0] modeWord,
    output logic [sdc_pkg::NUM_BANKS-1:0] bankOpen,
    output logic [sdc_pkg::ADDR_W+sdc_pkg::BANK_W-1:0] refreshPtr,
    output logic selfRefresh
);
    localparam int DEPTH = 1 << DEPTH_W;
    localparam int IDX_FULL_W = sdc_pkg::ADDR_W + sdc_pkg::BANK_W + sdc_pkg::COL_W;
    typedef struct packed {
        logic gatePrev;
        sdc_pkg::sdc_power_e power;
        logic [sdc_pkg::NUM_BANKS-1:0] open;
        logic [sdc_pkg::NUM_BANKS-1:0][sdc_pkg::ADDR_W-1:0] row;
        logic [sdc_pkg::ADDR_W-1:0] mode;
        logic [sdc_pkg::ADDR_W+sdc_pkg::BANK_W-1:0] refPtr;
        logic [sdc_pkg::READ_LAT-1:0][1:0] maskPipe;
        logic [sdc_pkg::READ_LAT-1:0] rdPipe;
        logic [sdc_pkg::READ_LAT-1:0][DEPTH_W-1:0] idxPipe;
        logic [sdc_pkg::DATA_W-1:0] dqOut;
        logic [1:0] dqOe;
    } sdc_dev_s;
    sdc_dev_s state_reg;
    sdc_dev_s state_next;
    // One array per byte lane, so each lane has a single writer
    logic [sdc_pkg::BYTE_W-1:0] mem [2][DEPTH];
    logic edgeValid;
    logic [2:0] cmd;
    logic [sdc_pkg::BANK_W-1:0] bank;
    logic [DEPTH_W-1:0] wrIdx;
    logic doWrite;
    logic [1:0] wrMask;

    // Row folded onto column: low columns of one row never collide; others may alias
    function automatic logic [DEPTH_W-1:0] sdc_index(
        input logic [sdc_pkg::BANK_W-1:0] b,
        input logic [sdc_pkg::ADDR_W-1:0] r,
        input logic [sdc_pkg::COL_W-1:0] c
    );
        logic [IDX_FULL_W-1:0] full;
        full = {r, b, c};
        return full[DEPTH_W-1:0] ^ full[IDX_FULL_W-1 -: DEPTH_W];
    endfunction : sdc_index

    always_comb
    begin
        state_next = state_reg;
        // Gate sampled at the edge; a clocked model cannot stop its own clock
        edgeValid = link.clkGate && state_reg.gatePrev;
        cmd = {link.rowStrobeN, link.colStrobeN, link.writeStrobeN};
        bank = link.bankSelect;
        wrIdx = sdc_index(bank, state_reg.row[bank], link.addr[sdc_pkg::COL_W-1:0]);
        doWrite = 1'b0;
        wrMask = {link.upperByteMask, link.lowerByteMask};
        state_next.gatePrev = link.clkGate;
        // Read pipeline: data and mask both two clocks after capture
        state_next.maskPipe = {state_reg.maskPipe[0], wrMask};
        state_next.rdPipe = {state_reg.rdPipe[0], 1'b0};
        state_next.idxPipe = {state_reg.idxPipe[0], wrIdx};
        state_next.dqOut = {mem[1][state_reg.idxPipe[sdc_pkg::READ_LAT-1]],
            mem[0][state_reg.idxPipe[sdc_pkg::READ_LAT-1]]};
        state_next.dqOe = state_reg.rdPipe[sdc_pkg::READ_LAT-1] ?
            ~state_reg.maskPipe[sdc_pkg::READ_LAT-1] : 2'h0;
        if (state_reg.gatePrev && !link.clkGate)
        begin
            // Falling gate picks the low-power state from current activity
            if (!link.chipSelN && cmd == sdc_pkg::CMD_REF && state_reg.open == '0)
            begin
                state_next.power = sdc_pkg::SDC_SELFREF;
            end
            else if (state_reg.open == '0)
            begin
                state_next.power = sdc_pkg::SDC_PDOWN;
            end
            else
            begin
                state_next.power = sdc_pkg::SDC_SUSPEND;
            end
        end
        else if (link.clkGate)
        begin
            state_next.power = sdc_pkg::SDC_RUN;
        end
        if (state_reg.power == sdc_pkg::SDC_SELFREF)
        begin
            state_next.refPtr = state_reg.refPtr + 1'b1;
        end
        if (edgeValid && !link.chipSelN)
        begin
            unique case (cmd)
                sdc_pkg::CMD_ACT:
                begin
                    state_next.open[bank] = 1'b1;
                    state_next.row[bank] = link.addr;
                end
                sdc_pkg::CMD_RD:
                begin
                    if (state_reg.open[bank])
                    begin
                        state_next.rdPipe[0] = 1'b1;
                        // Burst of one: bit ten set closes the bank right after this access
                        state_next.open[bank] = !link.addr[sdc_pkg::AP_BIT];
                    end
                end
                sdc_pkg::CMD_WR:
                begin
                    if (state_reg.open[bank])
                    begin
                        doWrite = 1'b1;
                        state_next.open[bank] = !link.addr[sdc_pkg::AP_BIT];
                    end
                end
                sdc_pkg::CMD_PRE:
                begin
                    if (link.addr[sdc_pkg::AP_BIT])
                    begin
                        state_next.open = '0;
                    end
                    else
                    begin
                        state_next.open[bank] = 1'b0;
                    end
                end
                sdc_pkg::CMD_REF:
                begin
                    state_next.refPtr = state_reg.refPtr + 1'b1;
                end
                sdc_pkg::CMD_MRS:
                begin
                    state_next.mode = link.addr;
                end
                sdc_pkg::CMD_NOP, sdc_pkg::CMD_BST:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Storage kept out of the state struct; byte lanes written separately
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gLane
            always_ff @(posedge clk)
            begin
                if (doWrite && !wrMask[g])
                begin
                    mem[g][wrIdx] <= link.dqFromCtrl[g*sdc_pkg::BYTE_W +: sdc_pkg::BYTE_W];
                end
            end
        end
    endgenerate

    assign link.dqFromMem = state_reg.dqOut;
    assign link.dqOeMem = state_reg.dqOe;
    assign modeWord = state_reg.mode;
    assign bankOpen = state_reg.open;
    assign refreshPtr = state_reg.refPtr;
    assign selfRefresh = state_reg.power == sdc_pkg::SDC_SELFREF;
endmodule : sdc_device

// File: design/sdc_ctrl.sv
// Controller end: one request at a time, timed precharge and refresh
`timescale 1ns/1ps
module sdc_ctrl #(
    parameter int REFRESH_GAP = sdc_pkg::REFRESH_GAP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    sdc_if.ctrl link,
    input wire logic reqValid,
    input wire logic [2:0] reqCmd,
    input wire logic [sdc_pkg::BANK_W-1:0] reqBank,
    input wire logic [sdc_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [1:0] reqMask,
    input wire logic [sdc_pkg::DATA_W-1:0] reqData,
    input wire logic reqGate,
    output logic reqReady,
    output logic [sdc_pkg::DATA_W-1:0] rdData,
    output logic rdValid
);
    // Due early: a precharge wait and the accept lag must still fit in the gap
    localparam int REFRESH_DUE = REFRESH_GAP - sdc_pkg::PRECHARGE_CYC - 1;
    typedef struct packed {
        logic [sdc_pkg::RC_CNT_W-1:0] wait_;
        logic [sdc_pkg::RC_CNT_W-1:0] refCnt;
        logic gate;
        logic csN;
        logic [2:0] cmd;
        logic [sdc_pkg::BANK_W-1:0] bank;
        logic [sdc_pkg::ADDR_W-1:0] addr;
        logic [1:0] mask;
        logic [sdc_pkg::DATA_W-1:0] data;
        logic [1:0] oe;
        logic ready;
        logic [sdc_pkg::DATA_W-1:0] rd;
        logic rdV;
    } sdc_ctl_s;
    sdc_ctl_s s_reg;
    sdc_ctl_s s_next;
    logic refDue;

    always_comb
    begin
        s_next = s_reg;
        refDue = s_reg.refCnt >= sdc_pkg::RC_CNT_W'(REFRESH_DUE);
        s_next.csN = 1'b1;
        s_next.cmd = sdc_pkg::CMD_NOP;
        s_next.oe = 2'h0;
        s_next.gate = reqGate;
        s_next.rdV = link.dqOeMem != 2'h0;
        s_next.rd = link.dqFromMem;
        s_next.refCnt = s_reg.refCnt + 1'b1;
        if (s_reg.wait_ != '0)
        begin
            s_next.wait_ = s_reg.wait_ - 1'b1;
        end
        else if (refDue)
        begin
            // Refresh preempts requests; all banks assumed idle by user
            s_next.csN = 1'b0;
            s_next.cmd = sdc_pkg::CMD_REF;
            s_next.refCnt = '0;
            s_next.wait_ = sdc_pkg::RC_CNT_W'(sdc_pkg::ROW_CYCLE_CYC);
        end
        else if (reqValid && s_reg.ready)
        begin
            s_next.csN = 1'b0;
            s_next.cmd = reqCmd;
            s_next.bank = reqBank;
            s_next.addr = reqAddr;
            s_next.mask = reqMask;
            s_next.data = reqData;
            if (reqCmd == sdc_pkg::CMD_WR)
            begin
                s_next.oe = 2'h3;
            end
            if (reqCmd == sdc_pkg::CMD_PRE)
            begin
                s_next.wait_ = sdc_pkg::RC_CNT_W'(sdc_pkg::PRECHARGE_CYC);
            end
            else if (reqCmd == sdc_pkg::CMD_REF)
            begin
                s_next.refCnt = '0;
                s_next.wait_ = sdc_pkg::RC_CNT_W'(sdc_pkg::ROW_CYCLE_CYC);
            end
        end
        // Looks one edge ahead, so a refresh never preempts an accepted request
        s_next.ready = s_next.wait_ == '0 && s_next.refCnt < sdc_pkg::RC_CNT_W'(REFRESH_DUE);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.csN <= 1'b1;
            s_reg.cmd <= sdc_pkg::CMD_NOP;
            s_reg.gate <= 1'b1;
            s_reg.mask <= 2'h3;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign link.clkGate = s_reg.gate;
    assign link.chipSelN = s_reg.csN;
    assign {link.rowStrobeN, link.colStrobeN, link.writeStrobeN} = s_reg.cmd;
    assign link.bankSelect = s_reg.bank;
    assign link.addr = s_reg.addr;
    assign {link.upperByteMask, link.lowerByteMask} = s_reg.mask;
    assign link.dqFromCtrl = s_reg.data;
    assign link.dqOeCtrl = s_reg.oe;
    assign reqReady = s_reg.ready;
    assign rdData = s_reg.rd;
    assign rdValid = s_reg.rdV;
endmodule : sdc_ctrl

// File: testbench/sdc_link_sva.sv
// Link checker: command capture, read answer, masks, write drive, refresh gap
`timescale 1ns/1ps
module sdc_link_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkGate,
    input wire logic chipSelN,
    input wire logic rowStrobeN,
    input wire logic colStrobeN,
    input wire logic writeStrobeN,
    input wire logic [sdc_pkg::BANK_W-1:0] bankSelect,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic lowerByteMask,
    input wire logic upperByteMask,
    input wire logic [1:0] dqOeCtrl,
    input wire logic [1:0] dqOeMem
);
    logic gatePrev_reg;
    logic [3:0] openBanks_reg;
    logic [2:0] cmd;
    logic [1:0] maskN;
    logic take, rdOk;
    logic [15:0] refGap_reg;
    assign cmd = {rowStrobeN, colStrobeN, writeStrobeN};
    assign maskN = ~{upperByteMask, lowerByteMask};
    assign take = !chipSelN && clkGate && gatePrev_reg;
    assign rdOk = take && cmd == sdc_pkg::CMD_RD && openBanks_reg[bankSelect];
    // Shadow of bank state, so the read answer can be predicted
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            gatePrev_reg <= 1'b0;
            openBanks_reg <= 4'h0;
            refGap_reg <= 16'h0000;
        end
        else
        begin
            gatePrev_reg <= clkGate;
            // Gated edges count as self refresh, which keeps rows alive itself
            if ((take && cmd == sdc_pkg::CMD_REF) || !clkGate || !gatePrev_reg)
                refGap_reg <= 16'h0000;
            else
                refGap_reg <= refGap_reg + 1'b1;
            if (take && cmd == sdc_pkg::CMD_ACT)
                openBanks_reg[bankSelect] <= 1'b1;
            else if (take && cmd == sdc_pkg::CMD_PRE && addr[sdc_pkg::AP_BIT])
                openBanks_reg <= 4'h0;
            else if (take && (cmd == sdc_pkg::CMD_PRE
                || (cmd[2:1] == 2'h2 && addr[sdc_pkg::AP_BIT])))
                openBanks_reg[bankSelect] <= 1'b0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_RD_MASK: assert property (rdOk |-> ##3 dqOeMem == $past(maskN, 3))
        else $error("read answer does not follow the byte masks");
    AST_RD_IDLE: assert property (take && cmd == sdc_pkg::CMD_RD && !openBanks_reg[bankSelect]
        |-> ##3 dqOeMem == 2'h0)
        else $error("read to idle bank was answered");
    AST_OE_CAUSE: assert property (dqOeMem != 2'h0 |-> $past(rdOk, 3))
        else $error("device drives data without a read");
    AST_CS_IDLE: assert property (chipSelN |-> ##3 dqOeMem == 2'h0)
        else $error("command taken while deselected");
    AST_GATED: assert property (!clkGate || !gatePrev_reg |-> ##3 dqOeMem == 2'h0)
        else $error("gated edge took a read");
    AST_WR_DRIVE: assert property (dqOeCtrl != 2'h0 |-> !chipSelN && cmd == sdc_pkg::CMD_WR)
        else $error("controller drives data outside a write");
    AST_WR_SAME: assert property (!chipSelN && cmd == sdc_pkg::CMD_WR && !lowerByteMask
        |-> dqOeCtrl[0])
        else $error("write data not beside its command");
    AST_REF_GAP: assert property (take && cmd == sdc_pkg::CMD_REF
        |=> (chipSelN || cmd == sdc_pkg::CMD_NOP) [*2])
        else $error("command inside refresh row cycle");
    AST_REF_RATE: assert property (refGap_reg < 16'(sdc_pkg::REFRESH_GAP_CYC))
        else $error("refresh interval too long");
    COV_RD: cover property (rdOk);
    COV_WR: cover property (take && cmd == sdc_pkg::CMD_WR);
    COV_REF: cover property (take && cmd == sdc_pkg::CMD_REF);
endmodule : sdc_link_sva

// File: testbench/sdram_command_bank_control_tb.sv
// Bench: controller and device joined, reads compared with a byte model
`timescale 1ns/1ps
module sdram_command_bank_control_tb;
    logic clk = 1'b0, rst = 1'b1, reqValid = 1'b0, reqGate = 1'b1;
    logic [2:0] reqCmd = 3'h7;
    logic [1:0] reqBank = 2'h0, reqMask = 2'h3;
    logic [11:0] reqAddr = 12'h000, modeWord, row;
    logic [15:0] reqData = 16'h0000, rdData;
    logic reqReady, rdValid, selfRefresh;
    logic [3:0] bankOpen, isOpen = 4'h0;
    logic [13:0] refreshPtr, p0, p1, p2;
    logic [31:0] r;
    int miscompares = 0, num_checks = 0, seed = 34559, i, ev;
    logic gateLast = 1'b0;
    int refs = 0, n0, n1, n2;
    int mem[int];
    int expQ[$];
    sdc_if link();
    always #12.5 clk = ~clk;
    sdc_ctrl #(.REFRESH_GAP(sdc_pkg::REFRESH_GAP_CYC)) sdc_ctrl_inst (.clk(clk), .rst(rst),
        .link(link.ctrl),
        .reqValid(reqValid), .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr),
        .reqMask(reqMask), .reqData(reqData), .reqGate(reqGate), .reqReady(reqReady),
        .rdData(rdData), .rdValid(rdValid));
    sdc_device sdc_device_inst (.clk(clk), .rst(rst), .link(link.device), .modeWord(modeWord),
        .bankOpen(bankOpen), .refreshPtr(refreshPtr), .selfRefresh(selfRefresh));
    sdc_link_sva sdc_link_sva_inst (.clk(clk), .rst(rst), .clkGate(link.clkGate),
        .chipSelN(link.chipSelN), .rowStrobeN(link.rowStrobeN), .colStrobeN(link.colStrobeN),
        .writeStrobeN(link.writeStrobeN), .bankSelect(link.bankSelect), .addr(link.addr),
        .lowerByteMask(link.lowerByteMask), .upperByteMask(link.upperByteMask),
        .dqOeCtrl(link.dqOeCtrl), .dqOeMem(link.dqOeMem));
    task automatic fail(input string msg);
        miscompares++;
        $display("Error at %0t: %s", $time, msg);
    endtask : fail
    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok)
            fail(msg);
    endtask : check
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // Byte model of storage and bank state; masked bytes are never stored
    task automatic model(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic [1:0] m, input logic [15:0] d);
        int e;
        e = m << 16;
        if (c == sdc_pkg::CMD_ACT)
            isOpen[b] = 1'b1;
        else if (c == sdc_pkg::CMD_PRE)
            isOpen = a[10] ? 4'h0 : isOpen & ~(4'h1 << b);
        else if ((c == sdc_pkg::CMD_WR || c == sdc_pkg::CMD_RD) && isOpen[b])
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (c == sdc_pkg::CMD_WR && !m[k])
                    mem[b * 512 + a[7:0] * 2 + k] = d[k * 8 +: 8];
                e = e | (mem[b * 512 + a[7:0] * 2 + k] << (k * 8));
            end
            if (c == sdc_pkg::CMD_RD)
                expQ.push_back(e);
            isOpen[b] = !a[10];
        end
    endtask : model
    task automatic req(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
        input logic [1:0] m, input logic [15:0] d, input logic g);
        int n;
        n = 0;
        @(negedge clk);
        {reqValid, reqCmd, reqBank, reqAddr, reqMask, reqData} = {1'b1, c, b, a, m, d};
        // Ready moves only on a rising edge, so it is settled here
        while (reqReady !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 500)
            fail("request not accepted");
        // Gate moves with the accepted command, so a gated refresh enters self refresh
        reqGate = g;
        @(posedge clk);
        model(c, b, a, m, d);
        @(negedge clk);
        reqValid = 1'b0;
    endtask : req
    task automatic settle();
        repeat (8) @(negedge clk);
        check(bankOpen === isOpen, "bank state");
        check(expQ.size() == 0, "read not answered");
    endtask : settle
    // Refresh commands the device takes, for the internal counter model
    always @(posedge clk)
    begin
        if (!rst && link.chipSelN === 1'b0 && link.clkGate === 1'b1 && gateLast === 1'b1
            && {link.rowStrobeN, link.colStrobeN, link.writeStrobeN} === sdc_pkg::CMD_REF)
            refs++;
        gateLast <= link.clkGate;
    end
    always @(negedge clk)
    begin
        if (rdValid === 1'b1 && expQ.size() == 0)
            fail("read data without a read");
        else if (rdValid === 1'b1)
        begin
            ev = expQ.pop_front();
            check(((rdData ^ ev[15:0]) & ~{{8{ev[17]}}, {8{ev[16]}}}) === 16'h0000, "read data");
        end
    end
    initial
    begin
        #(25 * 30000);
        fail("watchdog expired");
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        row = 12'($random(seed));
        req(sdc_pkg::CMD_MRS, 2'h0, ~row, 2'h3, 16'h0000, 1'b1);
        repeat (4) @(negedge clk);
        check(modeWord === ~row, "mode word");
        for (i = 0; i < 4; i++)
            req(sdc_pkg::CMD_ACT, i[1:0], row, 2'h3, 16'h0000, 1'b1);
        settle();
        for (i = 0; i < 64; i++)
            req(sdc_pkg::CMD_WR, i[5:4], {6'h00, i[5:0]}, 2'h0, 16'($random(seed)), 1'b1);
        for (i = 0; i < 80; i++)
        begin
            r = $random(seed);
            req(r[0] ? sdc_pkg::CMD_WR : sdc_pkg::CMD_RD, r[5:4], {6'h00, r[5:0]},
                (!r[0] && r[7:6] == 2'h3) ? 2'h0 : r[7:6], r[31:16], 1'b1);
        end
        settle();
        $display("data test done");
        req(sdc_pkg::CMD_RD, 2'h0, 12'h403, 2'h0, 16'h0000, 1'b1);
        req(sdc_pkg::CMD_RD, 2'h0, 12'h003, 2'h0, 16'h0000, 1'b1);
        req(sdc_pkg::CMD_WR, 2'h1, 12'h411, 2'h1, 16'hBEEF, 1'b1);
        req(sdc_pkg::CMD_RD, 2'h2, 12'h022, 2'h0, 16'h0000, 1'b1);
        settle();
        req(sdc_pkg::CMD_PRE, 2'h2, 12'h000, 2'h3, 16'h0000, 1'b1);
        settle();
        req(sdc_pkg::CMD_PRE, 2'h0, 12'h400, 2'h3, 16'h0000, 1'b1);
        settle();
        $display("precharge test done");
        p0 = refreshPtr;
        n0 = refs;
        req(sdc_pkg::CMD_REF, 2'h1, 12'hFFF, 2'h3, 16'h0000, 1'b1);
        repeat (6) @(negedge clk);
        p1 = refreshPtr;
        n1 = refs;
        req(sdc_pkg::CMD_REF, 2'h2, 12'h000, 2'h3, 16'h0000, 1'b1);
        repeat (6) @(negedge clk);
        p2 = refreshPtr;
        n2 = refs;
        check(p1 - p0 === 14'(n1 - n0) && p2 - p1 === 14'(n2 - n1) && n1 != n0,
            "refresh counter step");
        req(sdc_pkg::CMD_REF, 2'h0, 12'h000, 2'h3, 16'h0000, 1'b0);
        repeat (6) @(negedge clk);
        check(selfRefresh === 1'b1, "self refresh entry");
        reqGate = 1'b1;
        repeat (8) @(negedge clk);
        check(selfRefresh === 1'b0, "self refresh exit");
        req(sdc_pkg::CMD_ACT, 2'h3, row, 2'h3, 16'h0000, 1'b1);
        req(sdc_pkg::CMD_RD, 2'h3, 12'h033, 2'h0, 16'h0000, 1'b1);
        settle();
        $display("refresh test done");
        conclude();
    end
endmodule : sdram_command_bank_control_tb
